// *** logic/spp_defs.svh ***
// Purpose: constants of the serial peripheral port
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   field positions are bit indexes in the low byte
// Overview of operation
// RULE1 - software sets select enable, drives select low, then loads the data register; the code drives select low itself while the master runs
// RULE2 - in master mode a data write starts shifting out and in together
// RULE3 - a finished word sets the complete flag until software clears it
// RULE4 - in slave mode each external clock pulse shifts one bit each way
// RULE5 - with the port disabled all four pins are released to shared use
// RULE6 - with select enable low the select line floats and is ignored
// RULE7 - enabled and idle, data in floats and data out stays high; a slave with select enable low drives the shifter's outgoing bit instead
// RULE8 - master holds the idle clock level set by the polarity bit
// RULE9 - slave leaves its clock pin floating and uses the external clock
// RULE10 - master always makes the clock, starting only after a data write
// RULE11 - a three-bit mode field picks master or slave and clock rate
// RULE12 - bit order must match on master and slave before enabling
// RULE13 - received bits gather internally, latched readable only when complete
// RULE14 - a data write during a transfer is blocked and sets collision flag
// RULE15 - hardware sets the collision flag, only software clears it
// RULE16 - software checks collision, polls complete, reads data, clears, repeats
// RULE17 - in slave mode software loads the word before the master selects
// RULE18 - the port uses clock, data in, data out and active-low select
// RULE19 - polarity bit high rests the clock low, low rests it high
// RULE20 - bit order one means msb first, zero means lsb first
// RULE21 - the complete flag can raise the serial port interrupt request
// RULE22 - each transfer moves one eight-bit word
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

`define SPP_ADR_CTRL0    8'h00
`define SPP_ADR_CTRL1    8'h04
`define SPP_ADR_DATA     8'h08

`define SPP_C0_EN        1
`define SPP_C0_MODE_LO   5
`define SPP_C0_MODE_HI   7

`define SPP_C1_CPOL      5
`define SPP_C1_CEDGE     4
`define SPP_C1_MSB       3
`define SPP_C1_SELEN     2
`define SPP_C1_WCOL      1
`define SPP_C1_TRF       0

`define SPP_RST_CTRL0    8'h00
`define SPP_RST_CTRL1    8'h00
`define SPP_RST_DATA     8'h00

`define SPP_MODE_SLAVE   3'h5
// two-stage data-in sync needs three core cycles between drive and sample
`define SPP_HALF_BASE    10'h003
`define SPP_WORD_BITS    8

`endif

// *** logic/spp_pkg.sv ***
// Purpose: types of the serial peripheral port
// Assumes: nothing
// Notes:   none
package spp_pkg;
	typedef logic [7:0] spp_byte_t;
	typedef enum logic { SPP_IDLE, SPP_RUN } spp_state_e;
endpackage : spp_pkg

// *** logic/spp_top.sv ***
// Purpose: serial peripheral port, master or slave
// Assumes: link pins asynchronous to the core clock
// Notes:   slave clock must stay well below core/4
`timescale 1ns/1ns
`default_nettype none
`include "spp_defs.svh"
module spp_top
	import spp_pkg::*;
#(
	parameter int WORD_BITS = `SPP_WORD_BITS
) (
	// clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	// wishbone slave
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	// serial clock pin
	input  wire logic        I_SCK,
	output logic             O_SCK,
	output logic             O_SCK_OE_N,
	// data pins
	input  wire logic        I_SDI,
	output logic             O_SDO,
	output logic             O_SDO_OE_N,
	// select pin, active low
	input  wire logic        I_SCS_N,
	output logic             O_SCS_N,
	output logic             O_SCS_OE_N,
	// pin ownership and request
	output logic             O_PORT_OWNS_PINS,
	output logic             O_XFER_DONE_IRQ
);

////////////////////////////////////////////////////////////////////////

function automatic logic out_bit(
	input logic [WORD_BITS-1:0] v,
	input logic                 msb
);
	out_bit = msb ? v[WORD_BITS-1] : v[0];
endfunction : out_bit

function automatic logic [WORD_BITS-1:0] shift_in(
	input logic [WORD_BITS-1:0] v,
	input logic                 msb,
	input logic                 b
);
	if (msb) begin
		shift_in = {v[WORD_BITS-2:0], b};
	end else begin
		shift_in = {b, v[WORD_BITS-1:1]};
	end
endfunction : shift_in

////////////////////////////////////////////////////////////////////////

logic [2:0]           mode;
logic                 port_en;
logic                 cpol;
logic                 cedge;
logic                 msb_first;
logic                 sel_en;
logic                 wcol;
logic                 trf;
logic [WORD_BITS-1:0] rx_data;
logic [WORD_BITS-1:0] sh;
logic                 sdo_q;
logic                 sck_q;
logic [9:0]           div_cnt;
logic [4:0]           edge_cnt;
logic [3:0]           bit_cnt;
logic                 s_busy;
spp_state_e           state;
logic                 sck_m;
logic                 sck_s;
logic                 sck_d;
logic                 sdi_m;
logic                 sdi_s;
logic                 scs_m;
logic                 scs_s;

logic                 is_master;
logic                 idle_lvl;
logic [9:0]           half;
logic                 m_run;
logic                 m_edge;
logic                 m_lead;
logic                 s_act;
logic                 s_edge;
logic                 s_lead;
logic                 edge_any;
logic                 lead;
logic                 sample;
logic                 drive;
logic                 m_done;
logic                 s_done;
logic                 done;
logic                 busy;
logic                 acc;
logic                 wr;
logic                 wr_c0;
logic                 wr_c1;
logic                 wr_data;
logic                 load;
logic [31:0]          next_rdat;

////////////////////////////////////////////////////////////////////////
// input synchronisers

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		sck_m <= 1'b0;
		sck_s <= 1'b0;
		sck_d <= 1'b0;
		sdi_m <= 1'b0;
		sdi_s <= 1'b0;
		scs_m <= 1'b1;
		scs_s <= 1'b1;
	end else begin
		sck_m <= I_SCK;
		sck_s <= sck_m;
		sck_d <= sck_s;
		sdi_m <= I_SDI;
		sdi_s <= sdi_m;
		scs_m <= I_SCS_N;
		scs_s <= scs_m;
	end
end

////////////////////////////////////////////////////////////////////////
// decode of controls

assign is_master = (mode != `SPP_MODE_SLAVE); // RULE11
assign idle_lvl  = ~cpol;                     // RULE19

// modes above the slave code reuse the slowest rate
always_comb begin
	if (mode > 3'h4) begin
		half = `SPP_HALF_BASE << 8;
	end else begin
		half = `SPP_HALF_BASE << {mode, 1'b0}; // RULE11
	end
end

assign m_run  = (state == SPP_RUN);
assign m_edge = m_run && (div_cnt == half - 10'h001);
assign m_lead = m_edge && (sck_q == idle_lvl);

// select ignored when its enable is low
assign s_act  = port_en && !is_master
	&& (!sel_en || !scs_s); // RULE6
assign s_edge = s_act && (sck_s != sck_d); // RULE9
assign s_lead = s_edge && (sck_d == idle_lvl);

assign edge_any = is_master ? m_edge : s_edge;
assign lead     = is_master ? m_lead : s_lead;
assign sample   = edge_any && (cedge ? !lead : lead);
assign drive    = edge_any && !sample;

assign m_done = m_edge
	&& (edge_cnt == 5'(2 * WORD_BITS - 1)); // RULE22
assign s_done = sample && !is_master
	&& (bit_cnt == 4'(WORD_BITS - 1)); // RULE4
assign done   = m_done || s_done;
assign busy   = m_run || s_busy;

////////////////////////////////////////////////////////////////////////
// wishbone access

assign acc     = I_WB_CYC && I_WB_STB;
assign wr      = acc && I_WB_WE && O_WB_ACK && I_WB_SEL[0];
assign wr_c0   = wr && (I_WB_ADR == `SPP_ADR_CTRL0);
assign wr_c1   = wr && (I_WB_ADR == `SPP_ADR_CTRL1);
assign wr_data = wr && (I_WB_ADR == `SPP_ADR_DATA);
assign load    = wr_data && !busy && port_en; // RULE14

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		O_WB_ACK <= 1'b0;
	end else begin
		O_WB_ACK <= acc && !O_WB_ACK;
	end
end

always_comb begin
	next_rdat = 32'h0000_0000;
	unique case (I_WB_ADR)
		`SPP_ADR_CTRL0: begin
			next_rdat[`SPP_C0_MODE_HI:`SPP_C0_MODE_LO] = mode;
			next_rdat[`SPP_C0_EN] = port_en;
		end
		`SPP_ADR_CTRL1: begin
			next_rdat[`SPP_C1_CPOL]  = cpol;
			next_rdat[`SPP_C1_CEDGE] = cedge;
			next_rdat[`SPP_C1_MSB]   = msb_first;
			next_rdat[`SPP_C1_SELEN] = sel_en;
			next_rdat[`SPP_C1_WCOL]  = wcol;
			next_rdat[`SPP_C1_TRF]   = trf;
		end
		`SPP_ADR_DATA: begin
			next_rdat[WORD_BITS-1:0] = rx_data; // RULE13
		end
		default: begin
			next_rdat = 32'h0000_0000;
		end
	endcase
end

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		O_WB_DAT <= 32'h0000_0000;
	end else if (acc && !O_WB_ACK) begin
		O_WB_DAT <= next_rdat;
	end
end

////////////////////////////////////////////////////////////////////////
// control registers

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		mode    <= 3'(`SPP_RST_CTRL0 >> `SPP_C0_MODE_LO);
		port_en <= 1'b0;
	end else if (wr_c0) begin
		mode    <= I_WB_DAT[`SPP_C0_MODE_HI:`SPP_C0_MODE_LO];
		port_en <= I_WB_DAT[`SPP_C0_EN];
	end
end

// bit order is software's to keep matched with the peer
always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		cpol      <= 1'b0;
		cedge     <= 1'b0;
		msb_first <= 1'b0;
		sel_en    <= 1'b0;
	end else if (wr_c1) begin
		cpol      <= I_WB_DAT[`SPP_C1_CPOL];
		cedge     <= I_WB_DAT[`SPP_C1_CEDGE];
		msb_first <= I_WB_DAT[`SPP_C1_MSB]; // RULE20
		sel_en    <= I_WB_DAT[`SPP_C1_SELEN];
	end
end

// flags: writing zero clears, a same-cycle set wins
always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		trf  <= 1'b0;
		wcol <= 1'b0;
	end else begin
		if (done) begin
			trf <= 1'b1; // RULE3
		end else if (wr_c1 && !I_WB_DAT[`SPP_C1_TRF]) begin
			trf <= 1'b0;
		end
		if (wr_data && busy) begin
			wcol <= 1'b1; // RULE14
		end else if (wr_c1 && !I_WB_DAT[`SPP_C1_WCOL]) begin
			wcol <= 1'b0; // RULE15
		end
	end
end

////////////////////////////////////////////////////////////////////////
// master sequencing

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		state <= SPP_IDLE;
	end else if (!port_en || !is_master) begin
		state <= SPP_IDLE;
	end else begin
		unique case (state)
			SPP_IDLE: begin
				if (load) begin
					state <= SPP_RUN; // RULE2 RULE10
				end
			end
			SPP_RUN: begin
				if (m_done) begin
					state <= SPP_IDLE;
				end
			end
		endcase
	end
end

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		div_cnt  <= 10'h000;
		edge_cnt <= 5'h00;
		sck_q    <= 1'b1;
	end else if (!m_run) begin
		div_cnt  <= 10'h000;
		edge_cnt <= 5'h00;
		sck_q    <= idle_lvl; // RULE8
	end else if (m_edge) begin
		div_cnt  <= 10'h000;
		edge_cnt <= edge_cnt + 5'h01;
		sck_q    <= ~sck_q; // RULE10
	end else begin
		div_cnt  <= div_cnt + 10'h001;
	end
end

////////////////////////////////////////////////////////////////////////
// slave progress

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		s_busy <= 1'b0;
	end else if (!s_act || s_done) begin
		s_busy <= 1'b0;
	end else if (s_edge) begin
		s_busy <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// shifter, shared by both modes

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		bit_cnt <= 4'h0;
	end else if (load || (!is_master && !s_act) || done) begin
		bit_cnt <= 4'h0;
	end else if (sample) begin
		bit_cnt <= bit_cnt + 4'h1;
	end
end

always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		sh <= WORD_BITS'(`SPP_RST_DATA);
	end else if (load) begin
		sh <= I_WB_DAT[WORD_BITS-1:0]; // RULE17
	end else if (sample) begin
		sh <= shift_in(sh, msb_first, sdi_s); // RULE2 RULE4
	end
end

// only a whole word reaches the readable register
always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		rx_data <= WORD_BITS'(`SPP_RST_DATA);
	end else if (s_done) begin
		rx_data <= shift_in(sh, msb_first, sdi_s); // RULE13
	end else if (m_done) begin
		rx_data <= (sample) ? shift_in(sh, msb_first, sdi_s) : sh;
	end
end

// first bit must be valid before the first edge
always_ff @(posedge I_CORE_CLK) begin
	if (I_RST) begin
		sdo_q <= 1'b1;
	end else if (load) begin
		sdo_q <= out_bit(I_WB_DAT[WORD_BITS-1:0], msb_first);
	end else if (drive || !busy) begin
		sdo_q <= out_bit(sh, msb_first);
	end
end

////////////////////////////////////////////////////////////////////////
// pins: output enables are active low

assign O_PORT_OWNS_PINS = port_en; // RULE5 RULE18
assign O_SCK            = sck_q;
assign O_SCK_OE_N       = !(port_en && is_master); // RULE9
assign O_SDO            = (m_run || s_act) ? sdo_q : 1'b1; // RULE7
assign O_SDO_OE_N       = !port_en; // RULE5
assign O_SCS_N          = !m_run; // RULE1
assign O_SCS_OE_N       = !(port_en && is_master && sel_en); // RULE6
assign O_XFER_DONE_IRQ  = trf; // RULE21

endmodule : spp_top
`default_nettype wire

// *** dv/spp_top_checker.sv ***
// Purpose: port-level checks of spp_top
// Assumes: single core clock domain
// Notes:   master idle clock check skips two cycles after an ack, idle data check one
`timescale 1ns/1ns
`default_nettype none
module spp_top_checker (
	input wire logic        I_CORE_CLK, I_RST, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK,
	input wire logic [7:0]  I_WB_ADR,
	input wire logic [3:0]  I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic        O_SCK, O_SCK_OE_N, O_SDO, O_SDO_OE_N, O_SCS_N, O_SCS_OE_N,
	input wire logic        O_PORT_OWNS_PINS, O_XFER_DONE_IRQ
);
	wire logic wr = O_WB_ACK && I_WB_WE && I_WB_SEL[0];
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	////////////////////////////////////////////////////////////////
	a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack held too long");
	a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("request not answered");
	a_flag_holds: assert property (O_XFER_DONE_IRQ
		&& !(wr && I_WB_ADR == 8'h04 && !I_WB_DAT[0]) |=> O_XFER_DONE_IRQ)
		else $error("complete flag dropped");
	a_load_starts: assert property (wr && I_WB_ADR == 8'h08 && O_SCS_N
		&& !O_SCK_OE_N |-> ##[1:2] !O_SCS_N) else $error("load did not start");
	a_done_flags: assert property ($rose(O_SCS_N) && !O_SCK_OE_N
		|-> ##[0:2] O_XFER_DONE_IRQ) else $error("no flag at frame end");
	a_idle_sck: assert property (!O_SCK_OE_N && O_SCS_N && $past(O_SCS_N)
		&& $past(O_SCS_N, 2) && !$past(O_WB_ACK) && !$past(O_WB_ACK, 2) |-> $stable(O_SCK))
		else $error("clock moved while idle");
	a_idle_sdo: assert property (!O_SCK_OE_N && O_SCS_N && $past(O_SCS_N)
		&& $past(O_SCS_N, 2) && !$past(O_WB_ACK) |-> O_SDO) else $error("idle data low");
	a_pins_free: assert property (!O_PORT_OWNS_PINS
		|-> O_SCK_OE_N && O_SDO_OE_N && O_SCS_OE_N) else $error("pin kept");
	a_sdo_drive: assert property (O_PORT_OWNS_PINS |-> !O_SDO_OE_N)
		else $error("data out not driven");
	a_scs_master: assert property (!O_SCS_OE_N |-> !O_SCK_OE_N)
		else $error("select driven outside master");
endmodule : spp_top_checker
`default_nettype wire

// *** dv/spp_ext_slave.sv ***
// Purpose: external slave on the serial pins
// Assumes: clock edge set 0, wire seen msb-first
// Notes:   bench reorders for lsb-first runs
`timescale 1ns/1ns
`default_nettype none
module spp_ext_slave (
	// pins
	input  wire logic       i_sck,
	input  wire logic       i_sdo,
	input  wire logic       i_cs_n,
	input  wire logic       i_cpol,
	// user side
	input  wire logic [7:0] i_tx,
	output logic            o_sdi,
	output logic      [7:0] o_rx
);
	logic [7:0] sh;
	initial o_sdi = 1'h0;
	always @(negedge i_cs_n) begin
		sh = i_tx;
		o_sdi = sh[7];
	end
	// released line must not show the stale bit
	always @(posedge i_cs_n) o_sdi = ~o_sdi;
	always @(i_sck) begin
		if (!i_cs_n && i_sck === i_cpol) o_rx = {o_rx[6:0], i_sdo};
		else if (!i_cs_n) begin
			sh = sh << 1;
			o_sdi = sh[7];
		end
	end
endmodule : spp_ext_slave
`default_nettype wire

// *** dv/spp_top_test.sv ***
// Purpose: self-checking bench of spp_top
// Assumes: 4 ns core clock, 160 ns slave clock
// Notes:   every master mode code runs once, so the slowest rate runs three times
`timescale 1ns/1ns
`default_nettype none
module spp_top_test;
	import spp_pkg::*;
	logic        I_CORE_CLK, I_RST, I_WB_CYC, I_WB_STB, I_WB_WE, I_SCK, I_SCS_N;
	logic        O_WB_ACK, O_SCK, O_SCK_OE_N, O_SDO, O_SDO_OE_N, O_SCS_N, O_SCS_OE_N;
	logic        O_PORT_OWNS_PINS, O_XFER_DONE_IRQ, p_sdi, tb_sdi, smode, cpol;
	logic [7:0]  I_WB_ADR;
	logic [3:0]  I_WB_SEL;
	logic [31:0] I_WB_DAT, O_WB_DAT, q;
	wire logic   I_SDI = smode ? tb_sdi : p_sdi;
	spp_byte_t   p_tx, p_rx;
	int          mismatches, checked;
	logic [2:0]  md_l [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	spp_top u_dut (.*);
	spp_ext_slave u_peer (.i_sck(O_SCK), .i_sdo(O_SDO), .i_cs_n(O_SCS_OE_N | O_SCS_N),
		.i_cpol(cpol), .i_tx(p_tx), .o_sdi(p_sdi), .o_rx(p_rx));
	initial begin
		I_CORE_CLK = 1'h0;
		forever #2 I_CORE_CLK = ~I_CORE_CLK;
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge I_CORE_CLK);
	endtask : tick
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	function automatic spp_byte_t ord(input spp_byte_t v, input logic m);
		spp_byte_t r;
		for (int i = 0; i < 8; i++) r[i] = v[7-i];
		return m ? v : r;
	endfunction : ord
	task automatic wb(input logic w, input logic [7:0] a, input spp_byte_t d);
		int n;
		I_WB_CYC <= 1'h1;
		I_WB_STB <= 1'h1;
		I_WB_WE <= w;
		I_WB_SEL <= 4'h1;
		I_WB_ADR <= a;
		I_WB_DAT <= {24'h000000, d};
		n = 0;
		do begin
			tick(1);
			n++;
		end while (O_WB_ACK !== 1'h1 && n < 40);
		q = O_WB_DAT;
		if (n >= 40) chk("ack", 1, 0);
		I_WB_CYC <= 1'h0;
		I_WB_STB <= 1'h0;
		tick(1);
	endtask : wb
	task automatic mxfer(input logic [2:0] md, input logic col);
		spp_byte_t d, c1;
		logic m;
		int n;
		d = 8'($urandom);
		m = 1'($urandom);
		cpol = 1'($urandom);
		p_tx <= 8'($urandom);
		c1 = {2'h0, cpol, 1'h0, m, 1'h1, 2'h0};
		wb(1'h1, 8'h04, c1);
		wb(1'h1, 8'h00, {md, 5'h02});
		chk("sck idle", !cpol, O_SCK);
		chk("sdo idle", 1'h1, O_SDO);
		wb(1'h1, 8'h08, d);
		if (col) wb(1'h1, 8'h08, ~d);
		n = 0;
		while (O_XFER_DONE_IRQ !== 1'h1 && n < 20000) begin
			tick(1);
			n++;
		end
		if (n >= 20000) chk("done wait", 1, 0);
		chk("peer rx", ord(d, m), p_rx);
		wb(1'h0, 8'h08, 8'h00);
		chk("rx data", ord(p_tx, m), q);
		wb(1'h0, 8'h04, 8'h00);
		chk("ctrl1", c1 | {6'h00, col, 1'h1}, q);
		wb(1'h1, 8'h04, c1 | {6'h00, col, 1'h0});
		wb(1'h0, 8'h04, 8'h00);
		chk("wcol", c1 | {6'h00, col, 1'h0}, q);
		wb(1'h1, 8'h04, c1);
		chk("irq", 1'h0, O_XFER_DONE_IRQ);
	endtask : mxfer
	task automatic sxfer(input logic se);
		spp_byte_t d, mo, got;
		logic m, ce;
		d = 8'($urandom);
		mo = 8'($urandom);
		m = 1'($urandom);
		ce = !se;
		cpol = 1'($urandom);
		wb(1'h1, 8'h00, 8'h00);
		smode <= 1'h1;
		I_SCK <= !cpol;
		wb(1'h1, 8'h04, {2'h0, cpol, ce, m, se, 2'h0});
		wb(1'h1, 8'h00, 8'hA2);
		wb(1'h1, 8'h08, d);
		chk("sck oe", 1'h1, O_SCK_OE_N);
		chk("scs oe", 1'h1, O_SCS_OE_N);
		I_SCS_N <= !se;
		for (int i = 7; i >= 0; i--) begin
			tick(10);
			tb_sdi <= mo[i];
			tick(10);
			if (!ce) got[i] = O_SDO;
			I_SCK <= cpol;
			tick(20);
			if (ce) got[i] = O_SDO;
			I_SCK <= !cpol;
		end
		tick(20);
		I_SCS_N <= 1'h1;
		tb_sdi <= !mo[0];
		tick(10);
		chk("slave tx", ord(d, m), got);
		chk("slave irq", 1'h1, O_XFER_DONE_IRQ);
		wb(1'h0, 8'h08, 8'h00);
		chk("slave rx", ord(mo, m), q);
		wb(1'h1, 8'h04, 8'h00);
		smode <= 1'h0;
	endtask : sxfer
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////
	initial begin
		{I_RST, I_SCS_N, I_SCK} = 3'h7;
		{I_WB_CYC, I_WB_STB, I_WB_WE, tb_sdi, smode, cpol} = 6'h00;
		{I_WB_ADR, I_WB_SEL, I_WB_DAT, p_tx} = 52'h1000000000;
		mismatches = 0;
		checked = 0;
		void'($urandom(32'h992D4D2A));
		tick(12);
		I_RST <= 1'h0;
		tick(1);
		for (int a = 0; a < 16; a += 4) begin
			wb(1'h0, 8'(a), 8'h00);
			chk("reset", 0, q);
		end
		$display("test reset done");
		foreach (md_l[i]) mxfer(md_l[i], i == 2);
		chk("owns", 1'h1, O_PORT_OWNS_PINS);
		$display("test master done");
		sxfer(1'h1);
		sxfer(1'h0);
		$display("test slave done");
		wb(1'h1, 8'h00, 8'h00);
		chk("pins", 4'h7, {O_PORT_OWNS_PINS, O_SCK_OE_N, O_SDO_OE_N, O_SCS_OE_N});
		$display("test disable done");
		give_verdict();
	end
	initial begin
		tick(60000);
		mismatches++;
		give_verdict();
	end
endmodule : spp_top_test
bind spp_top spp_top_checker u_chk (.*);
`default_nettype wire
